// [rtl/usp_dev.sv]
// usp_dev: device end of the serial host port, and the host end beside it
// assumes: link pins arrive asynchronously and are sampled on I_CLK
//
// How it works
// - mode 0, clock idles low
// - every frame is sixteen bits both ways
// - first two bits select transfer type
// - device samples input on rising clock
// - host samples device output on rising clock
// - bit 15 driven when select falls
// - bits 14..0 change on falling clock
// - short frame aborted, nothing written
// - effects happen when select rises
// - counter restarts on every select fall
// - output released while select is high
module usp_dev
	import usp_pkg::*;
(
	input  wire logic      I_CLK,
	input  wire logic      I_RESET,
	input  wire logic      I_CE,
	usp_if.dev             LINK,
	input  wire usp_word_t I_RESP,
	output usp_word_t      O_CMD,
	output usp_kind_e      O_KIND,
	output logic           O_CMD_VLD,
	output logic           O_ABORT,
	output logic           O_BUSY
);
	typedef struct packed {
		logic            cs_d;
		logic            sclk_d;
		logic            busy;
		logic [CNT_W-1:0] cnt;
		usp_word_t       rx;
		usp_word_t       tx;
		logic            miso;
		usp_word_t       cmd;
		usp_kind_e       kind;
		logic            vld;
		logic            abort;
	} usp_dev_s;

	usp_dev_s st_r;
	usp_dev_s st_nxt;
	logic     cs_n_s;
	logic     sclk_s;
	logic     mosi_s;

	usp_sync u_cs (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_ce(I_CE), .i_d(LINK.cs_n),
		.i_rst_val(1'b1), .o_q(cs_n_s));
	usp_sync u_ck (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_ce(I_CE), .i_d(LINK.sclk),
		.i_rst_val(1'b0), .o_q(sclk_s));
	usp_sync u_di (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_ce(I_CE), .i_d(LINK.mosi),
		.i_rst_val(1'b0), .o_q(mosi_s));

	always_comb begin
		st_nxt        = st_r;
		st_nxt.vld    = 1'b0;
		st_nxt.abort  = 1'b0;
		st_nxt.cs_d   = cs_n_s;
		st_nxt.sclk_d = sclk_s;
		if (st_r.cs_d && !cs_n_s) begin
			st_nxt.busy = 1'b1;
			st_nxt.cnt  = '0;
			st_nxt.tx   = I_RESP;
			st_nxt.miso = I_RESP[FRAME_BITS-1];
		end else if (!st_r.cs_d && cs_n_s) begin
			st_nxt.busy = 1'b0;
			if (st_r.busy && st_r.cnt == CNT_W'(FRAME_BITS)) begin
				st_nxt.cmd  = st_r.rx;
				st_nxt.kind = usp_kind_e'(st_r.rx[TYPE_MSB:TYPE_LSB]);
				st_nxt.vld  = 1'b1;
			end else if (st_r.busy) begin
				st_nxt.abort = 1'b1;
			end
		end else if (st_r.busy) begin
			if (!st_r.sclk_d && sclk_s && st_r.cnt < CNT_W'(FRAME_BITS)) begin
				st_nxt.rx  = {st_r.rx[FRAME_BITS-2:0], mosi_s};
				st_nxt.cnt = st_r.cnt + CNT_W'(1);
			end
			if (st_r.sclk_d && !sclk_s && st_r.cnt != '0) begin
				st_nxt.tx   = {st_r.tx[FRAME_BITS-2:0], 1'b0};
				st_nxt.miso = st_r.tx[FRAME_BITS-2];
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			st_r        <= '0;
			st_r.cs_d   <= 1'b1;
			st_r.tx     <= RESP_RESET;
			st_r.kind   <= USP_RD_DATA;
		end else if (I_CE) begin
			st_r <= st_nxt;
		end
	end

	assign LINK.miso    = st_r.miso;
	assign LINK.miso_oe = st_r.busy;
	assign O_CMD        = st_r.cmd;
	assign O_KIND       = st_r.kind;
	assign O_CMD_VLD    = st_r.vld;
	assign O_ABORT      = st_r.abort;
	assign O_BUSY       = st_r.busy;
endmodule // usp_dev

module usp_host
	import usp_pkg::*;
(
	input  wire logic      I_CLK,
	input  wire logic      I_RESET,
	input  wire logic      I_CE,
	usp_if.host            LINK,
	input  wire logic      I_START,
	input  wire usp_word_t I_CMD,
	output logic           O_READY,
	output usp_word_t      O_RESP,
	output logic           O_DONE
);
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_HOLD} usp_hst_e;

	typedef struct packed {
		usp_hst_e         state;
		logic [7:0]       tmr;
		logic [CNT_W-1:0] cnt;
		logic             cs_n;
		logic             sclk;
		usp_word_t        tx;
		usp_word_t        rx;
		usp_word_t        resp;
		logic             done;
	} usp_hst_s;

	usp_hst_s st_r;
	usp_hst_s st_nxt;
	logic     miso_s;

	usp_sync u_do (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_ce(I_CE), .i_d(LINK.miso),
		.i_rst_val(1'b0), .o_q(miso_s));

	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		unique case (st_r.state)
			H_IDLE: begin
				if (I_START) begin
					st_nxt.state = H_SETUP;
					st_nxt.cs_n  = 1'b0;
					st_nxt.tx    = I_CMD;
					st_nxt.cnt   = '0;
					st_nxt.tmr   = 8'(CS_GAP_CYC + 2);
				end
			end
			H_SETUP: begin
				if (st_r.tmr == '0) begin
					st_nxt.state = H_SHIFT;
					st_nxt.tmr   = 8'(SCLK_HALF_CYC + 2);
				end else begin
					st_nxt.tmr = st_r.tmr - 8'h01;
				end
			end
			H_SHIFT: begin
				if (st_r.tmr != '0) begin
					st_nxt.tmr = st_r.tmr - 8'h01;
				end else if (!st_r.sclk) begin
					st_nxt.sclk = 1'b1;
					st_nxt.rx   = {st_r.rx[FRAME_BITS-2:0], miso_s};
					st_nxt.cnt  = st_r.cnt + CNT_W'(1);
					st_nxt.tmr  = 8'(SCLK_HALF_CYC + 2);
				end else begin
					st_nxt.sclk = 1'b0;
					st_nxt.tx   = {st_r.tx[FRAME_BITS-2:0], 1'b0};
					st_nxt.tmr  = 8'(SCLK_HALF_CYC + 2);
					if (st_r.cnt == CNT_W'(FRAME_BITS)) begin
						st_nxt.state = H_HOLD;
						st_nxt.tmr   = 8'(CS_GAP_CYC + 2);
					end
				end
			end
			H_HOLD: begin
				if (st_r.tmr != '0) begin
					st_nxt.tmr = st_r.tmr - 8'h01;
				end else if (!st_r.cs_n) begin
					st_nxt.cs_n = 1'b1;
					st_nxt.resp = st_r.rx;
					st_nxt.done = 1'b1;
					st_nxt.tmr  = 8'(CS_GAP_CYC + 2);
				end else begin
					st_nxt.state = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			st_r       <= '0;
			st_r.state <= H_IDLE;
			st_r.cs_n  <= 1'b1;
		end else if (I_CE) begin
			st_r <= st_nxt;
		end
	end

	assign LINK.cs_n = st_r.cs_n;
	assign LINK.sclk = st_r.sclk;
	assign LINK.mosi = st_r.tx[FRAME_BITS-1];
	assign O_READY   = (st_r.state == H_IDLE);
	assign O_RESP    = st_r.resp;
	assign O_DONE    = st_r.done;
endmodule // usp_host

// [rtl/usp_pkg.sv]
// usp_pkg: constants and frame types shared by both ends of the serial host port
// assumes: both ends run on one 100 MHz system clock and meet in usp_if
package usp_pkg;
	localparam int unsigned FRAME_BITS   = 16;
	localparam int unsigned CNT_W        = 5;
	localparam int unsigned TYPE_MSB     = 15;
	localparam int unsigned TYPE_LSB     = 14;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// host serial clock half period, in ns and in system cycles
	localparam int unsigned SCLK_HALF_NS  = 60;
	localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// select setup and hold around the clock burst
	localparam int unsigned CS_GAP_NS     = 60;
	localparam int unsigned CS_GAP_CYC    = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] RESP_RESET    = 16'h0000;

	typedef logic [FRAME_BITS-1:0] usp_word_t;

	typedef enum logic [1:0] {
		USP_WR_DATA = 2'h2,
		USP_RD_DATA = 2'h0,
		USP_WR_CFG  = 2'h3,
		USP_RD_CFG  = 2'h1
	} usp_kind_e;
endpackage : usp_pkg

// [rtl/usp_if.sv]
// usp_if: the four wires between host and device, plus the device's data out enable
// assumes: device data out only carries meaning while its enable is high
interface usp_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;

	modport host (
		output cs_n,
		output sclk,
		output mosi,
		input  miso
	);
	modport dev (
		input  cs_n,
		input  sclk,
		input  mosi,
		output miso,
		output miso_oe
	);
endinterface : usp_if

// [rtl/usp_sync.sv]
// usp_sync: two-flop synchroniser for one level
// assumes: input comes from another clock domain
module usp_sync (
	input  wire logic I_CLK,
	input  wire logic I_RESET,
	input  wire logic i_ce,
	input  wire logic i_d,
	input  wire logic i_rst_val,
	output logic      o_q
);
	logic [1:0] sh_r;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			sh_r <= {2{i_rst_val}};
		end else if (i_ce) begin
			sh_r <= {sh_r[0], i_d};
		end
	end
	// both stages start at the pin's idle level, so no false edge follows reset
	assign o_q = sh_r[1];
endmodule // usp_sync

// [testbench/usp_properties.sv]
// usp_properties: link checks beside the host and device ends
// assumes: inputs are the usp_if wires, sampled on the system clock
module usp_properties (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic miso,
	input wire logic miso_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("clock high while deselected");
	AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*4])
		else $error("clock too soon after select");
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[2:6] miso_oe)
		else $error("data out not driven after select");
	AST_OE_OFF: assert property (cs_n [*6] |-> !miso_oe)
		else $error("data out driven while deselected");
	AST_MISO_HOLD: assert property ($rose(sclk) |-> $stable(miso))
		else $error("data out moved at rising clock");
	AST_MISO_LOW: assert property (miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk)
		else $error("data out moved while clock high");
	AST_SCLK_PULSE: assert property ($rose(sclk) |-> !cs_n throughout ##[4:12] $fell(sclk))
		else $error("clock pulse outside select");
	AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n [*5])
		else $error("select gap too short");
	cover property ($rose(cs_n));
	cover property ($rose(miso_oe));
	cover property ($rose(sclk) && miso);
endmodule // usp_properties

// [testbench/test_uart_spi_host_port.sv]
// test_uart_spi_host_port: host and device joined, plus a device driven by hand
// assumes: usp_pkg, usp_if, usp_host and usp_dev are compiled first
module test_uart_spi_host_port
	import usp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic      I_CLK, I_RESET, st, rdy, dn, v, ab, ab2, ce, bz, bz2;
	usp_word_t cmd, rsp, hr, oc, oc2, r2, oe2;
	usp_kind_e kd, kd2;
	int        err_total, compares, nv, na, nab;
	bit [31:0] lf = 32'hdf01;
	usp_word_t exp_q[$];
	usp_if lk();
	usp_if lk2();
	usp_host usp_host_i(.I_CLK, .I_RESET, .I_CE(ce), .LINK(lk), .I_START(st), .I_CMD(cmd),
		.O_READY(rdy), .O_RESP(hr), .O_DONE(dn));
	usp_dev usp_dev_i(.I_CLK, .I_RESET, .I_CE(ce), .LINK(lk), .I_RESP(rsp), .O_CMD(oc),
		.O_KIND(kd), .O_CMD_VLD(v), .O_ABORT(ab), .O_BUSY(bz));
	usp_dev usp_dev_b_i(.I_CLK, .I_RESET, .I_CE(ce), .LINK(lk2), .I_RESP(rsp), .O_CMD(oc2),
		.O_KIND(kd2), .O_CMD_VLD(), .O_ABORT(ab2), .O_BUSY(bz2));
	usp_properties usp_properties_i(.I_CLK, .I_RESET, .cs_n(lk.cs_n), .sclk(lk.sclk),
		.miso(lk.miso), .miso_oe(lk.miso_oe));
	initial begin
		I_CLK = 1'b0;
		forever #5 I_CLK = ~I_CLK;
	end
	always @(posedge I_CLK) begin
		if (v === 1'b1) nv++;
		if (ab2 === 1'b1) na++;
		if (ab === 1'b1) nab++;
	end
	function automatic bit [31:0] nx(bit [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(usp_word_t seen, usp_word_t exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// hand-driven frame of n bits, msb first, collecting data out at each rising clock;
	// the low phase alternates 6 and 7 cycles, a 125 ns clock period on average
	task automatic bang(int n, usp_word_t w);
		lk2.cs_n <= 1'b0;
		repeat (6) @(posedge I_CLK);
		for (int i = 15; i > 15 - n; i--) begin
			lk2.mosi <= w[i];
			repeat (6 + (i & 1)) @(posedge I_CLK);
			lk2.sclk <= 1'b1;
			r2[i] = lk2.miso;
			oe2[i] = lk2.miso_oe;
			repeat (6) @(posedge I_CLK);
			lk2.sclk <= 1'b0;
		end
		repeat (6) @(posedge I_CLK);
		lk2.cs_n <= 1'b1;
		lk2.mosi <= ~lk2.mosi;
		repeat (12) @(posedge I_CLK);
	endtask
	initial begin
		I_RESET = 1'b1;
		st = 1'b0;
		cmd = 16'h0000;
		rsp = 16'h0000;
		ce = 1'b1;
		lk2.cs_n = 1'b1;
		lk2.sclk = 1'b0;
		lk2.mosi = 1'b0;
		repeat (16) @(posedge I_CLK);
		I_RESET <= 1'b0;
		for (int t = 0; t < 8; t++) begin
			lf = nx(lf);
			exp_q.push_back({t[1:0], lf[13:0]});
			@(posedge I_CLK);
			st <= 1'b1;
			cmd <= {t[1:0], lf[13:0]};
			rsp <= lf[29:14];
			@(posedge I_CLK);
			st <= 1'b0;
			if (t == 5) begin
				// freeze both ends in a low clock phase; the host must not raise the clock
				repeat (50) @(posedge I_CLK);
				ce <= 1'b0;
				repeat (10) @(posedge I_CLK);
				chk(16'({lk.cs_n, lk.sclk}), 16'h0000);
				repeat (10) @(posedge I_CLK);
				ce <= 1'b1;
			end
			for (int j = 0; j < 400 && dn !== 1'b1; j++) @(posedge I_CLK);
			chk(hr, rsp);
			chk(16'(rdy), 16'h0000);
			repeat (12) @(posedge I_CLK);
			chk(16'({rdy, bz}), 16'h0002);
			chk(oc, exp_q.pop_front());
			chk(16'(kd), 16'(t[1:0]));
			chk(16'(nv), 16'(t + 1));
			$display("frame %0d done", t);
		end
		bang(16, 16'h8c3a);
		chk(oc2, 16'h8c3a);
		chk(r2, rsp);
		chk(oe2, 16'hffff);
		chk(16'(kd2), 16'h0002);
		chk(16'({lk2.miso_oe, bz2}), 16'h0000);
		bang(9, 16'h5a5a);
		chk(16'(na), 16'h0001);
		chk(oc2, 16'h8c3a);
		bang(16, 16'h13e7);
		chk(oc2, 16'h13e7);
		chk(16'(kd2), 16'h0000);
		chk(16'(nab), 16'h0000);
		$display("abort test done");
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge I_CLK);
		err_total++;
		end_of_test();
	end
endmodule // test_uart_spi_host_port
